// ### hw/cgo_regs.sv
// Channel gain, offset and channel order register bank with sample sequencer.
// Assumes a master on the plain register port that never overlaps strobes,
// and strobes synchronous to ref_clk_i.
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ps
module cgo_regs (
    input  wire logic                      ref_clk_i,
    input  wire logic                      rst_i,
    input  wire logic [2:0]                reg_addr_i,
    input  wire logic [8:0]                reg_wdata_i,
    input  wire logic                      reg_wr_i,
    input  wire logic                      reg_rd_i,
    output logic      [8:0]                reg_rdata_o,
    input  wire logic                      cds_mode_i,
    input  wire logic                      three_ch_mode_i,
    input  wire logic                      reference_sample_strobe_i,
    input  wire logic                      data_sample_strobe_i,
    output logic                           clamp_on_o,
    output logic                           ref_captured_o,
    output logic                           sample_valid_o,
    output cgo_pkg::cgo_sample_t           sample_o,
    output logic                           offset_pin_sampled_o,
    output logic      [1:0]                next_chan_o
);
    typedef enum logic [2:0] {
        CGO_RED   = 3'h1,
        CGO_GREEN = 3'h2,
        CGO_BLUE  = 3'h4
    } cgo_mux_t;

    typedef struct packed {
        logic [8:0]           order_sel;
        logic [2:0][5:0]      gain;
        logic [2:0][8:0]      offs;
        cgo_mux_t             mux;
        logic [8:0]           rdata;
        logic                 valid;
        cgo_pkg::cgo_sample_t smp;
        logic                 ofs_pin;
        logic                 ref_cap;
    } cgo_state_t;

    cgo_state_t                st_r;
    cgo_state_t                st_nxt;
    logic                      ref_fall;
    logic                      data_fall;
    cgo_pkg::cgo_sample_ctl_t  sctl;
    logic                      order_rgb;
    logic [2:0]                sel;
    logic [1:0]                sel_cnt;
    cgo_mux_t                  first_ch;
    cgo_mux_t                  step_ch;
    logic [1:0]                cur_code;

    cgo_strobe_ctl u_strobe (
        .ref_clk_i                 (ref_clk_i),
        .rst_i                     (rst_i),
        .cds_mode_i                (cds_mode_i),
        .reference_sample_strobe_i (reference_sample_strobe_i),
        .data_sample_strobe_i      (data_sample_strobe_i),
        .ref_fall_o                (ref_fall),
        .data_fall_o               (data_fall),
        .ctl_o                     (sctl)
    );

    // Selection decode from the order register
    assign order_rgb = st_r.order_sel[cgo_pkg::ORDER_BIT];
    assign sel = {st_r.order_sel[cgo_pkg::SEL_BLUE_BIT], st_r.order_sel[cgo_pkg::SEL_GREEN_BIT],
                  st_r.order_sel[cgo_pkg::SEL_RED_BIT]};
    assign sel_cnt = 2'(sel[0]) + 2'(sel[1]) + 2'(sel[2]);

    // Channel code of the current mux position
    always_comb begin
        case (st_r.mux)
            CGO_RED:   cur_code = cgo_pkg::CH_RED;
            CGO_GREEN: cur_code = cgo_pkg::CH_GREEN;
            CGO_BLUE:  cur_code = cgo_pkg::CH_BLUE;
            default:   cur_code = cgo_pkg::CH_RED;
        endcase
    end

    // First channel of the active order among enabled channels
    always_comb begin
        first_ch = CGO_RED;
        if (three_ch_mode_i) begin
            first_ch = order_rgb ? CGO_RED : CGO_BLUE;
        end else if (order_rgb) begin
            if (sel[0]) first_ch = CGO_RED;
            else if (sel[1]) first_ch = CGO_GREEN;
            else if (sel[2]) first_ch = CGO_BLUE;
        end else begin
            if (sel[2]) first_ch = CGO_BLUE;
            else if (sel[1]) first_ch = CGO_GREEN;
            else if (sel[0]) first_ch = CGO_RED;
        end
    end

    // Next channel after the current one; the first channel of the order in three-channel mode, fixed in one-channel mode
    always_comb begin
        step_ch = first_ch;
        if (three_ch_mode_i) begin
            // Every data strobe restarts the sequence at the first channel of the order
            step_ch = first_ch;
        end else if (sel_cnt == 2'h2) begin
            // Alternate between the two enabled channels in order
            step_ch = (st_r.mux == first_ch) ? cgo_mux_t'(sel & ~first_ch) : first_ch;
        end else begin
            step_ch = first_ch;
        end
    end

    // Register writes, reads and sample sequencing
    always_comb begin
        st_nxt         = st_r;
        st_nxt.valid   = 1'b0;
        st_nxt.ofs_pin = 1'b0;
        st_nxt.ref_cap = sctl.ref_held;
        if (reg_wr_i) begin
            case (reg_addr_i)
                cgo_pkg::OFS_ORDER_SEL:  st_nxt.order_sel = reg_wdata_i & cgo_pkg::ORDER_SEL_MASK;
                cgo_pkg::OFS_GAIN_RED:   st_nxt.gain[0] = reg_wdata_i[5:0];
                cgo_pkg::OFS_GAIN_GREEN: st_nxt.gain[1] = reg_wdata_i[5:0];
                cgo_pkg::OFS_GAIN_BLUE:  st_nxt.gain[2] = reg_wdata_i[5:0];
                cgo_pkg::OFS_OFFS_RED:   st_nxt.offs[0] = reg_wdata_i;
                cgo_pkg::OFS_OFFS_GREEN: st_nxt.offs[1] = reg_wdata_i;
                cgo_pkg::OFS_OFFS_BLUE:  st_nxt.offs[2] = reg_wdata_i;
                default: ;
            endcase
        end
        // Read data stands for one cycle only
        st_nxt.rdata = 9'h000;
        if (reg_rd_i) begin
            case (reg_addr_i)
                cgo_pkg::OFS_ORDER_SEL:  st_nxt.rdata = st_r.order_sel;
                cgo_pkg::OFS_GAIN_RED:   st_nxt.rdata = {3'h0, st_r.gain[0]};
                cgo_pkg::OFS_GAIN_GREEN: st_nxt.rdata = {3'h0, st_r.gain[1]};
                cgo_pkg::OFS_GAIN_BLUE:  st_nxt.rdata = {3'h0, st_r.gain[2]};
                cgo_pkg::OFS_OFFS_RED:   st_nxt.rdata = st_r.offs[0];
                cgo_pkg::OFS_OFFS_GREEN: st_nxt.rdata = st_r.offs[1];
                cgo_pkg::OFS_OFFS_BLUE:  st_nxt.rdata = st_r.offs[2];
                default:                 st_nxt.rdata = 9'h000;
            endcase
        end
        // Data strobe fall closes one sample with the live settings
        if (data_fall) begin
            st_nxt.valid     = 1'b1;
            st_nxt.ofs_pin   = sctl.sub_offset_pin;
            st_nxt.smp.chan  = cur_code;
            st_nxt.smp.gain  = st_r.gain[cur_code];
            st_nxt.smp.offs  = st_r.offs[cur_code];
            st_nxt.mux       = step_ch;
        end else if (!three_ch_mode_i && (sel_cnt != 2'h2 || (sel & st_r.mux) == 3'h0)) begin
            // A mux left on a deselected channel would sample the wrong input
            st_nxt.mux = first_ch;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            st_r           <= '0;
            st_r.order_sel <= cgo_pkg::ORDER_SEL_RST;
            st_r.gain      <= '0;
            st_r.offs      <= '0;
            st_r.mux       <= CGO_RED;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata_o          = st_r.rdata;
    assign clamp_on_o           = sctl.clamp_on;
    assign ref_captured_o       = st_r.ref_cap;
    assign sample_valid_o       = st_r.valid;
    assign sample_o             = st_r.smp;
    assign offset_pin_sampled_o = st_r.ofs_pin;
    assign next_chan_o          = cur_code;

    AST_ORDER_MASK: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (st_r.order_sel & ~cgo_pkg::ORDER_SEL_MASK) == 9'h000) else $error("order bits leak");
    AST_GAIN_RB: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        reg_wr_i && reg_addr_i == cgo_pkg::OFS_GAIN_RED ##1 reg_rd_i && reg_addr_i == cgo_pkg::OFS_GAIN_RED
        && !reg_wr_i |=> reg_rdata_o == {3'h0, $past(reg_wdata_i[5:0], 2)}) else $error("gain readback");
    AST_OFFS_RB: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        reg_rd_i && reg_addr_i == cgo_pkg::OFS_OFFS_BLUE |=> reg_rdata_o == $past(st_r.offs[2])) else $error("offset readback");
    AST_SAMPLE_GAIN: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        data_fall |=> sample_valid_o && sample_o.gain == $past(st_r.gain[cur_code])) else $error("sample gain");
    AST_SAMPLE_OFFS: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        sample_valid_o |-> sample_o.offs == $past(st_r.offs[cur_code])) else $error("sample offset");
    AST_THREE_RESET: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        three_ch_mode_i && data_fall && st_r.mux == CGO_BLUE && order_rgb |=> st_r.mux == CGO_RED) else $error("mux restart");
    AST_ONE_FIXED: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !three_ch_mode_i && sel_cnt == 2'h1 && $stable(st_r.order_sel) ##1 data_fall |=> $stable(st_r.mux)) else $error("mux moved");
    AST_REF_CAP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        cds_mode_i && reference_sample_strobe_i ##1 !reference_sample_strobe_i |=> ref_captured_o) else $error("ref capture");
    AST_TH_OFFSET: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        sample_valid_o |-> offset_pin_sampled_o == !$past(cds_mode_i)) else $error("offset pin sample");
endmodule : cgo_regs

// ### hw/cgo_pkg.sv
// Package for the channel gain and offset register bank.
// Assumes a single 50 MHz clock and a plain address/strobe register port.
package cgo_pkg;
    // Register word width and offsets
    localparam int          REG_W          = 9;
    localparam int          ADDR_W         = 3;
    localparam logic [2:0]  OFS_ORDER_SEL  = 3'h1;
    localparam logic [2:0]  OFS_GAIN_RED   = 3'h2;
    localparam logic [2:0]  OFS_GAIN_GREEN = 3'h3;
    localparam logic [2:0]  OFS_GAIN_BLUE  = 3'h4;
    localparam logic [2:0]  OFS_OFFS_RED   = 3'h5;
    localparam logic [2:0]  OFS_OFFS_GREEN = 3'h6;
    localparam logic [2:0]  OFS_OFFS_BLUE  = 3'h7;
    // Field positions
    localparam int          ORDER_BIT      = 7;
    localparam int          SEL_RED_BIT    = 6;
    localparam int          SEL_GREEN_BIT  = 5;
    localparam int          SEL_BLUE_BIT   = 4;
    localparam int          OFFS_SIGN_BIT  = 8;
    localparam int          GAIN_W         = 6;
    localparam int          MAG_W          = 8;
    // Writable masks: other bits are forced to zero
    localparam logic [8:0]  ORDER_SEL_MASK = 9'h0F0;
    localparam logic [8:0]  GAIN_MASK      = 9'h03F;
    localparam logic [8:0]  OFFS_MASK      = 9'h1FF;
    // Reset values
    localparam logic [8:0]  ORDER_SEL_RST  = 9'h0C0;
    localparam logic [8:0]  GAIN_RST       = 9'h000;
    localparam logic [8:0]  OFFS_RST       = 9'h000;
    // Offset step in microvolts, full scale in millivolts
    localparam int          OFFS_STEP_UV   = 1200;
    localparam int          OFFS_FULL_MV   = 300;
    // Channel codes
    localparam logic [1:0]  CH_RED         = 2'h0;
    localparam logic [1:0]  CH_GREEN       = 2'h1;
    localparam logic [1:0]  CH_BLUE        = 2'h2;

    typedef struct packed {
        logic [1:0]  chan;
        logic [5:0]  gain;
        logic [8:0]  offs;
    } cgo_sample_t;

    typedef struct packed {
        logic        clamp_on;
        logic        ref_held;
        logic        data_held;
        logic        sub_offset_pin;
    } cgo_sample_ctl_t;
endpackage : cgo_pkg

// ### hw/cgo_strobe_ctl.sv
// Strobe edge detection, clamp control and sample hold events.
// Assumes strobes are synchronous to ref_clk_i.
`timescale 1ns/1ps
module cgo_strobe_ctl (
    input  wire logic                      ref_clk_i,
    input  wire logic                      rst_i,
    input  wire logic                      cds_mode_i,
    input  wire logic                      reference_sample_strobe_i,
    input  wire logic                      data_sample_strobe_i,
    output logic                           ref_fall_o,
    output logic                           data_fall_o,
    output cgo_pkg::cgo_sample_ctl_t       ctl_o
);
    typedef struct packed {
        logic ref_d;
        logic data_d;
    } cgo_sc_state_t;

    cgo_sc_state_t st_r;
    cgo_sc_state_t st_nxt;

    // Previous strobe levels for edge detection
    always_comb begin
        st_nxt        = st_r;
        st_nxt.ref_d  = reference_sample_strobe_i;
        st_nxt.data_d = data_sample_strobe_i;
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Reference fall only counts in double sampling mode
    assign ref_fall_o  = cds_mode_i & st_r.ref_d & ~reference_sample_strobe_i;
    assign data_fall_o = st_r.data_d & ~data_sample_strobe_i;

    // Clamp follows the reference strobe level, never in track-hold
    assign ctl_o.clamp_on       = cds_mode_i & reference_sample_strobe_i;
    assign ctl_o.ref_held       = ref_fall_o;
    assign ctl_o.data_held      = data_fall_o;
    assign ctl_o.sub_offset_pin = ~cds_mode_i & data_fall_o;

    AST_CLAMP_OFF_TH: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !cds_mode_i |-> !ctl_o.clamp_on) else $error("clamp on in track-hold");
    AST_CLAMP_FOLLOWS: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        cds_mode_i |-> (ctl_o.clamp_on == reference_sample_strobe_i)) else $error("clamp mismatch");
    AST_DATA_FALL: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        data_sample_strobe_i ##1 !data_sample_strobe_i |-> data_fall_o) else $error("data fall missed");
endmodule : cgo_strobe_ctl

// ### testbench/cgo_ctrl_model.sv
// Controller model that drives the reference and data sample strobes.
// Assumes ref_clk_i from the bench and a one-cycle fire_i request while idle.
`timescale 1ns/1ps
module cgo_ctrl_model (
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    input  wire logic fire_i,
    input  wire logic ref_en_i,
    output logic      reference_sample_strobe_o,
    output logic      data_sample_strobe_o
);
    logic [2:0] step_r;

    // One strobe pair per request; a second request is ignored until idle
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            step_r <= 3'h0;
        end else if (step_r != 3'h0) begin
            step_r <= (step_r == 3'h6) ? 3'h0 : step_r + 3'h1;
        end else if (fire_i) begin
            step_r <= 3'h1;
        end
    end

    // Reference strobe first; ref_en_i low grounds it, which track-hold expects
    assign reference_sample_strobe_o = ref_en_i & ((step_r == 3'h1) | (step_r == 3'h2));
    // Data strobe falls at a step boundary, where a conversion clock would rise
    assign data_sample_strobe_o = (step_r == 3'h4) | (step_r == 3'h5);
endmodule : cgo_ctrl_model

// ### testbench/channel_gain_offset_regs_tb.sv
// Self-checking bench for the channel gain and offset register bank.
// Assumes cgo_pkg, cgo_regs and the controller model cgo_ctrl_model.
`timescale 1ns/1ps
module channel_gain_offset_regs_tb;
    logic                 ref_clk_i       = 1'b0;
    logic                 rst_i           = 1'b1;
    logic [2:0]           reg_addr_i      = 3'h0;
    logic [8:0]           reg_wdata_i     = 9'h000;
    logic                 reg_wr_i        = 1'b0;
    logic                 reg_rd_i        = 1'b0;
    logic                 cds_mode_i      = 1'b1;
    logic                 three_ch_mode_i = 1'b1;
    logic                 fire_r          = 1'b0;
    logic                 ref_en_r        = 1'b1;
    logic [8:0]           reg_rdata_o;
    logic                 ref_strobe;
    logic                 data_strobe;
    logic                 clamp_on_o;
    logic                 ref_captured_o;
    logic                 sample_valid_o;
    logic                 offset_pin_sampled_o;
    logic [1:0]           next_chan_o;
    cgo_pkg::cgo_sample_t sample_o;
    logic [5:0]           gains [3] = '{6'h05, 6'h2A, 6'h3F};
    logic [8:0]           offs  [3] = '{9'h101, 9'h0FF, 9'h1FF};
    int                   fail_count = 0;
    int                   checks     = 0;
    int                   ref_caps   = 0;

    cgo_regs cgo_regs_inst (
        .ref_clk_i                 (ref_clk_i),
        .rst_i                     (rst_i),
        .reg_addr_i                (reg_addr_i),
        .reg_wdata_i               (reg_wdata_i),
        .reg_wr_i                  (reg_wr_i),
        .reg_rd_i                  (reg_rd_i),
        .reg_rdata_o               (reg_rdata_o),
        .cds_mode_i                (cds_mode_i),
        .three_ch_mode_i           (three_ch_mode_i),
        .reference_sample_strobe_i (ref_strobe),
        .data_sample_strobe_i      (data_strobe),
        .clamp_on_o                (clamp_on_o),
        .ref_captured_o            (ref_captured_o),
        .sample_valid_o            (sample_valid_o),
        .sample_o                  (sample_o),
        .offset_pin_sampled_o      (offset_pin_sampled_o),
        .next_chan_o               (next_chan_o)
    );

    cgo_ctrl_model cgo_ctrl_model_inst (
        .ref_clk_i                 (ref_clk_i),
        .rst_i                     (rst_i),
        .fire_i                    (fire_r),
        .ref_en_i                  (ref_en_r),
        .reference_sample_strobe_o (ref_strobe),
        .data_sample_strobe_o      (data_strobe)
    );

    // 50 MHz clock
    always #10 ref_clk_i = ~ref_clk_i;

    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic close_out();
        $display("Mismatches %0d, comparisons %0d", fail_count, checks);
        if (fail_count == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out

    // Clamp sampled mid-cycle so strobe changes have settled
    always @(negedge ref_clk_i) begin
        if (!rst_i) chk(17'(clamp_on_o), 17'(cds_mode_i & ref_strobe));
    end

    // Reference capture pulses, counted once each
    always @(posedge ref_clk_i) begin
        if (ref_captured_o === 1'b1) ref_caps <= ref_caps + 1;
    end

    // Register write: strobe dropped one edge later, so calls leave a gap
    task automatic wr(input logic [2:0] a, input logic [8:0] d);
        @(posedge ref_clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i    <= 1'b0;
    endtask : wr

    // Register read: data valid only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, input logic [8:0] exp);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i   <= 1'b0;
        #1;
        chk({8'h00, reg_rdata_o}, {8'h00, exp});
    endtask : rd

    // One pixel through the controller, then the captured sample is compared
    task automatic pix(input logic [1:0] ch, input logic [5:0] g, input logic [8:0] o);
        int n;
        int caps0;
        caps0 = ref_caps;
        @(posedge ref_clk_i);
        fire_r <= 1'b1;
        #1;
        chk(17'(next_chan_o), 17'(ch));
        @(posedge ref_clk_i);
        fire_r <= 1'b0;
        for (n = 0; n < 20 && sample_valid_o !== 1'b1; n++) begin
            @(posedge ref_clk_i);
            #1;
        end
        if (n >= 20) begin
            fail_count++;
            close_out();
        end
        chk(sample_o, {ch, g, o});
        chk(17'(offset_pin_sampled_o), 17'(!cds_mode_i));
        @(posedge ref_clk_i);
        chk(17'(ref_caps - caps0), 17'(cds_mode_i));
    endtask : pix

    // Watchdog against a stalled sequence
    initial begin
        repeat (5000) @(posedge ref_clk_i);
        fail_count++;
        close_out();
    end

    initial begin
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        // Power-on values, index 0 unmapped
        for (int a = 0; a < 8; a++) rd(3'(a), (a == 1) ? 9'h0C0 : 9'h000);
        wr(3'h1, 9'h1FF);
        rd(3'h1, 9'h0F0);
        wr(3'h2, 9'h1FF);
        rd(3'h2, 9'h03F);
        wr(3'h0, 9'h1FF);
        rd(3'h0, 9'h000);
        // Distinct codes per channel, both signs and full magnitude
        for (int c = 0; c < 3; c++) begin
            wr(3'(c + 2), {3'h0, gains[c]});
            wr(3'(c + 5), offs[c]);
            rd(3'(c + 2), {3'h0, gains[c]});
            rd(3'(c + 5), offs[c]);
        end
        wr(3'h1, 9'h0C0);
        pix(cgo_pkg::CH_RED, gains[0], offs[0]);
        // Track-hold with the reference strobe still toggling
        cds_mode_i      <= 1'b0;
        three_ch_mode_i <= 1'b0;
        wr(3'h1, 9'h030);
        pix(cgo_pkg::CH_BLUE, gains[2], offs[2]);
        pix(cgo_pkg::CH_GREEN, gains[1], offs[1]);
        pix(cgo_pkg::CH_BLUE, gains[2], offs[2]);
        // Single channel stays fixed
        cds_mode_i <= 1'b1;
        wr(3'h1, 9'h0A0);
        pix(cgo_pkg::CH_GREEN, gains[1], offs[1]);
        pix(cgo_pkg::CH_GREEN, gains[1], offs[1]);
        // Two channels in forward order
        wr(3'h1, 9'h0D0);
        pix(cgo_pkg::CH_RED, gains[0], offs[0]);
        pix(cgo_pkg::CH_BLUE, gains[2], offs[2]);
        close_out();
    end
endmodule : channel_gain_offset_regs_tb
